// ===== inc/sep_pkg.sv
package sep_pkg;
	// Serial protocol opcodes; bits 7..4 must be zero and bit 3 is ignored.
	localparam logic [3:0] OPC_HIGH_ZERO       = 4'h0;
	localparam logic [2:0] OPC_SET_LATCH       = 3'h6;
	localparam logic [2:0] OPC_CLEAR_LATCH     = 3'h4;
	localparam logic [2:0] OPC_STATUS_READ     = 3'h5;
	localparam logic [2:0] OPC_STATUS_WRITE    = 3'h1;
	localparam logic [2:0] OPC_READ            = 3'h3;
	localparam logic [2:0] OPC_WRITE           = 3'h2;

	// Status word layout and reset values.
	localparam int         ST_BIT_BUSY         = 0;
	localparam int         ST_BIT_LATCH        = 1;
	localparam int         ST_BIT_GUARD_LO     = 2;
	localparam int         ST_BIT_GUARD_HI     = 3;
	localparam int         ST_BIT_PIN_EN       = 7;
	localparam logic [7:0] ST_BUSY_WORD        = 8'hFF;
	localparam logic [1:0] GUARD_RESET         = 2'h0;
	localparam logic       PIN_EN_RESET        = 1'h0;

	// Block guard encodings.
	localparam logic [1:0] GUARD_NONE          = 2'h0;
	localparam logic [1:0] GUARD_QUARTER       = 2'h1;
	localparam logic [1:0] GUARD_HALF          = 2'h2;
	localparam logic [1:0] GUARD_ALL           = 2'h3;

	// Page geometry.
	localparam int         PAGE_BYTES          = 64;
	localparam int         PAGE_BITS           = 6;
	localparam int         ADDR_BITS_DEFAULT   = 15;

	// Pin synchroniser lanes and their reset levels.
	localparam int         PIN_LANES           = 4;
	localparam int         LANE_CS_N           = 3;
	localparam int         LANE_SCK            = 2;
	localparam int         LANE_SI             = 1;
	localparam int         LANE_WP_N           = 0;
	localparam logic [3:0] PIN_RESET           = 4'h9;

	// Self-timed programming time.
	localparam int         CLK_PERIOD_NS       = 10;
	localparam int         T_PROG_MS           = 5;
	localparam int         PROG_CYCLES         = T_PROG_MS * 1000000 / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'h0,
		ST_CMD    = 3'h1,
		ST_ADDR   = 3'h2,
		ST_RDATA  = 3'h3,
		ST_WDATA  = 3'h4,
		ST_SRD    = 3'h5,
		ST_SWR    = 3'h6,
		ST_IGNORE = 3'h7
	} sep_state_t;
endpackage

// ===== src/sep_core.sv
`timescale 1ns/10ps
module sep_core
#(
	parameter int  AW       = sep_pkg::ADDR_BITS_DEFAULT,
	parameter int  PROG_CYC = sep_pkg::PROG_CYCLES
) (
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic       i_cs_n,
	input  wire logic       i_sck,
	input  wire logic       i_si,
	input  wire logic       i_wp_n,
	output logic            o_so,
	output logic            o_so_oe,
	output logic            o_busy,
	output logic            o_write_latch,
	output logic [1:0]      o_guard,
	output logic            o_pin_enable
);
	import sep_pkg::*;
	localparam int DEPTH = 1 << AW;
	localparam int CW    = $clog2(PROG_CYC + 1);

	logic [7:0]           mem [DEPTH];
	logic [7:0]           page_buf [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] page_mask;
	sep_state_t           state;
	sep_state_t           next_state;
	logic [2:0]           bitcnt;
	logic [6:0]           shreg;
	logic [7:0]           tx;
	logic                 addr_cnt;
	logic [7:0]           addr_hi;
	logic                 is_read;
	logic [AW-1:0]        rd_addr;
	logic [AW-1:0]        wr_base;
	logic [PAGE_BITS-1:0] page_off;
	logic                 byte_done;
	logic [7:0]           new_stat;
	logic                 prog_stat;
	logic [CW-1:0]        prog_cnt;

	logic [PIN_LANES-1:0] pin_lvl;
	logic [PIN_LANES-1:0] pin_rise;
	logic [PIN_LANES-1:0] pin_fall;

	sep_pin_sync #(
		.W   (PIN_LANES),
		.RST (PIN_RESET)
	) u_sync (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_pins  ({i_cs_n, i_sck, i_si, i_wp_n}),
		.o_level (pin_lvl),
		.o_rise  (pin_rise),
		.o_fall  (pin_fall)
	);

	wire                 cs_n_s    = pin_lvl[LANE_CS_N];
	wire                 cs_fall   = pin_fall[LANE_CS_N];
	wire                 cs_rise   = pin_rise[LANE_CS_N];
	wire                 sck_rise  = pin_rise[LANE_SCK] && !cs_n_s;
	wire                 sck_fall  = pin_fall[LANE_SCK] && !cs_n_s;
	wire                 si_s      = pin_lvl[LANE_SI];
	wire                 wp_n_s    = pin_lvl[LANE_WP_N];

	wire [7:0]           rx_byte   = {shreg, si_s};
	wire                 byte_end  = sck_rise && (bitcnt == 3'h7);
	wire                 op_ok     = (rx_byte[7:4] == OPC_HIGH_ZERO);
	wire [2:0]           op        = rx_byte[2:0];
	wire                 hw_prot   = !wp_n_s && o_pin_enable;
	wire [15:0]          addr16    = {addr_hi, rx_byte};
	wire [AW-1:0]        full_addr = addr16[AW-1:0];
	wire [7:0]           status_word = o_busy ? ST_BUSY_WORD :
		{o_pin_enable, 3'h0, o_guard, o_write_latch, 1'h0};
	wire                 cmd_ok    = op_ok && (!o_busy || op == OPC_STATUS_READ);
	wire [PAGE_BITS-1:0] prog_idx  = prog_cnt[PAGE_BITS-1:0];
	wire                 prog_page = prog_cnt < CW'(PAGE_BYTES);
	wire [AW-1:0]        mem_wa    = {wr_base[AW-1:PAGE_BITS], prog_idx};
	wire                 prog_last = prog_cnt == CW'(PROG_CYC - 1);
	wire                 mem_we    = o_busy && !prog_stat && prog_page &&
		page_mask[prog_idx] && !guarded(mem_wa, o_guard);
	wire                 stat_ok   = o_write_latch && !hw_prot;

	function automatic logic guarded(input logic [AW-1:0] a, input logic [1:0] g);
		return (g == GUARD_ALL) || (g == GUARD_HALF && a[AW-1]) ||
			(g == GUARD_QUARTER && a[AW-1:AW-2] == 2'h3);
	endfunction

	always_comb begin
		next_state = state;
		if (cs_fall) begin
			next_state = ST_CMD;
		end else if (cs_n_s) begin
			next_state = ST_IDLE;
		end else if (byte_end) begin
			unique case (state)
				ST_CMD: begin
					if (!cmd_ok) begin
						next_state = ST_IGNORE;
					end else if (op == OPC_STATUS_READ) begin
						next_state = ST_SRD;
					end else if (op == OPC_READ) begin
						next_state = ST_ADDR;
					end else if (op == OPC_WRITE) begin
						next_state = o_write_latch ? ST_ADDR : ST_IGNORE;
					end else if (op == OPC_STATUS_WRITE) begin
						next_state = o_write_latch ? ST_SWR : ST_IGNORE;
					end else begin
						next_state = ST_IGNORE;
					end
				end
				ST_ADDR: begin
					if (addr_cnt) begin
						next_state = is_read ? ST_RDATA : ST_WDATA;
					end
				end
				ST_IDLE, ST_RDATA, ST_WDATA, ST_SRD, ST_SWR, ST_IGNORE: begin
					next_state = state;
				end
			endcase
		end
	end

	// The array and the page buffer carry no reset, so they map to plain RAM.
	always_ff @(posedge i_clock) begin
		if (mem_we) begin
			mem[mem_wa] <= page_buf[prog_idx];
		end
		if (state == ST_WDATA && byte_end) begin
			page_buf[page_off] <= rx_byte;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			state         <= ST_IDLE;
			bitcnt        <= 3'h0;
			shreg         <= 7'h00;
			tx            <= 8'h00;
			addr_cnt      <= 1'h0;
			addr_hi       <= 8'h00;
			is_read       <= 1'h0;
			rd_addr       <= '0;
			wr_base       <= '0;
			page_off      <= '0;
			page_mask     <= '0;
			byte_done     <= 1'h0;
			new_stat      <= 8'h00;
			prog_stat     <= 1'h0;
			prog_cnt      <= '0;
			o_so          <= 1'h0;
			o_so_oe       <= 1'h0;
			o_busy        <= 1'h0;
			o_write_latch <= 1'h0;
			o_guard       <= GUARD_RESET;
			o_pin_enable  <= PIN_EN_RESET;
		end else begin
			state   <= next_state;
			o_so_oe <= (next_state == ST_RDATA) || (next_state == ST_SRD);
			if (cs_fall) begin
				bitcnt    <= 3'h0;
				addr_cnt  <= 1'h0;
				byte_done <= 1'h0;
				page_mask <= o_busy ? page_mask : '0;
			end else if (sck_rise) begin
				bitcnt    <= bitcnt + 3'h1;
				shreg     <= rx_byte[6:0];
				byte_done <= byte_end && (state == ST_WDATA || state == ST_SWR);
			end
			if (byte_end) begin
				unique case (state)
					ST_CMD: begin
						is_read <= op == OPC_READ;
						tx      <= status_word;
						if (cmd_ok && op == OPC_SET_LATCH) begin
							o_write_latch <= 1'h1;
						end else if (cmd_ok && op == OPC_CLEAR_LATCH) begin
							o_write_latch <= 1'h0;
						end
					end
					ST_ADDR: begin
						addr_cnt <= 1'h1;
						addr_hi  <= rx_byte;
						if (addr_cnt) begin
							tx       <= mem[full_addr];
							rd_addr  <= full_addr + AW'(1);
							wr_base  <= full_addr;
							page_off <= full_addr[PAGE_BITS-1:0];
						end
					end
					ST_RDATA: begin
						tx      <= mem[rd_addr];
						rd_addr <= rd_addr + AW'(1);
					end
					ST_WDATA: begin
						page_mask[page_off] <= 1'h1;
						page_off            <= page_off + PAGE_BITS'(1);
					end
					ST_SRD: begin
						tx <= status_word;
					end
					ST_SWR: begin
						new_stat <= rx_byte;
					end
					ST_IDLE, ST_IGNORE: begin
						tx <= tx;
					end
				endcase
			end
			if (sck_fall && (state == ST_RDATA || state == ST_SRD)) begin
				o_so <= tx[7];
				tx   <= {tx[6:0], 1'h0};
			end
			// Protection is judged at deselect, so a pin that drops mid-frame still blocks.
			if (cs_rise && byte_done && !o_busy) begin
				if (state == ST_WDATA) begin
					o_busy    <= 1'h1;
					prog_stat <= 1'h0;
					prog_cnt  <= '0;
				end else if (state == ST_SWR && stat_ok) begin
					o_busy    <= 1'h1;
					prog_stat <= 1'h1;
					prog_cnt  <= '0;
				end
			end
			if (o_busy) begin
				prog_cnt <= prog_cnt + CW'(1);
				if (prog_last) begin
					o_busy        <= 1'h0;
					o_write_latch <= 1'h0;
					if (prog_stat) begin
						o_guard      <= new_stat[ST_BIT_GUARD_HI:ST_BIT_GUARD_LO];
						o_pin_enable <= new_stat[ST_BIT_PIN_EN] || hw_prot;
					end
				end
			end
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_nrst);

	a_guard_blocks_prog: assert property ((o_busy && guarded(mem_wa, o_guard))
		|=> mem[$past(mem_wa)] === $past(mem[mem_wa]))
		else $error("Guarded byte programmed.");
	a_pin_enable_kept: assert property (hw_prot |=> o_pin_enable)
		else $error("Pin enable cleared under pin protection.");
	a_read_holds_state: assert property ((state == ST_RDATA && !cs_n_s && !cs_fall)
		|=> state == ST_RDATA)
		else $error("Read left early while selected.");
	a_read_addr_step: assert property ((state == ST_RDATA && byte_end)
		|=> rd_addr == $past(rd_addr) + AW'(1))
		else $error("Read address did not step.");
	a_busy_ignores_cmd: assert property ((state == ST_CMD && byte_end && o_busy &&
		op != OPC_STATUS_READ) |=> state == ST_IGNORE)
		else $error("Command accepted while programming.");
	a_prog_on_deselect: assert property ($rose(o_busy) |-> $past(cs_rise))
		else $error("Programming started without deselect.");
	a_busy_status_word: assert property ((state == ST_SRD && byte_end && o_busy)
		|=> tx == ST_BUSY_WORD)
		else $error("Status not all ones while busy.");
	a_idle_status_bit: assert property (state == ST_SRD && byte_end && !o_busy |=> !tx[0])
		else $error("Busy bit set while idle.");
	a_latch_after_prog: assert property ($fell(o_busy) |-> !o_write_latch)
		else $error("Write latch survived programming.");
	a_write_no_latch: assert property ((state == ST_CMD && byte_end && cmd_ok &&
		op == OPC_WRITE && !o_write_latch) |=> state == ST_IGNORE)
		else $error("Write accepted without latch.");
	a_partial_abandon: assert property ((cs_rise && !byte_done && !o_busy)
		|=> !o_busy)
		else $error("Partial byte started programming.");
endmodule

// ===== src/sep_pin_sync.sv
`timescale 1ns/10ps
module sep_pin_sync #(
	parameter int                 W   = 4,
	parameter logic [W-1:0]       RST = '0
) (
	input  wire logic             i_clock,
	input  wire logic             i_nrst,
	input  wire logic [W-1:0]     i_pins,
	output logic      [W-1:0]     o_level,
	output logic      [W-1:0]     o_rise,
	output logic      [W-1:0]     o_fall
);
	logic [W-1:0] meta;
	logic [W-1:0] stable;
	logic [W-1:0] prev;

	// Edges are taken from the second and third stages only, never from the first.
	always_ff @(posedge i_clock) begin
		if (!i_nrst) begin
			meta   <= RST;
			stable <= RST;
			prev   <= RST;
		end else begin
			meta   <= i_pins;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign o_level = stable;
	assign o_rise  = stable & ~prev;
	assign o_fall  = ~stable & prev;
endmodule

// ===== tb/sep_core_tb.sv
`timescale 1ns/10ps
module sep_core_tb;
	localparam int LIMIT = 60000;
	logic       i_clock;
	logic       i_nrst;
	logic       i_wp_n;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic       o_so;
	logic       o_so_oe;
	logic       o_busy;
	logic       o_write_latch;
	logic       o_pin_enable;
	logic [1:0] o_guard;
	logic [7:0] rx;
	logic [7:0] exp_mem [int];
	int         n_fail;
	int         checks;
	int         cyc;

	sep_core #(.AW(15), .PROG_CYC(1000)) uut (
		.i_clock(i_clock), .i_nrst(i_nrst), .i_cs_n(cs_n), .i_sck(sck), .i_si(si),
		.i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe), .o_busy(o_busy),
		.o_write_latch(o_write_latch), .o_guard(o_guard), .o_pin_enable(o_pin_enable)
	);
	sep_spi_master m (.i_so(o_so), .o_cs_n(cs_n), .o_sck(sck), .o_si(si));

	initial begin
		i_clock = 1'h0;
		forever #5 i_clock = ~i_clock;
	end

	task automatic wrap_up();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// A hung handshake would otherwise stall the run forever.
	always @(posedge i_clock) begin
		cyc = cyc + 1;
		if (cyc == LIMIT) begin
			n_fail++;
			wrap_up();
		end
	end

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e || $isunknown(g)) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		m.start();
		m.xfer(op, 8, rx);
		m.stop();
	endtask
	task automatic status(input logic [7:0] e);
		m.start();
		m.xfer(8'h05, 8, rx);
		m.xfer(8'h00, 8, rx);
		m.stop();
		chk("status", e, rx);
		chk("so enable", 8'h00, {7'h00, o_so_oe});
	endtask
	task automatic swr(input logic [7:0] v);
		m.start();
		m.xfer(8'h01, 8, rx);
		m.xfer(v, 8, rx);
		m.stop();
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d0, input int n);
		m.start();
		m.xfer(8'h02, 8, rx);
		m.xfer(a[15:8], 8, rx);
		m.xfer(a[7:0], 8, rx);
		for (int k = 0; k < n; k++) begin
			m.xfer(8'(d0 + k), 8, rx);
		end
		m.stop();
	endtask
	// Junk on the input line during data checks that it is not taken as a new command.
	task automatic rd(input logic [15:0] a, input int n);
		m.start();
		m.xfer(8'h03, 8, rx);
		m.xfer(a[15:8], 8, rx);
		m.xfer(a[7:0], 8, rx);
		for (int k = 0; k < n; k++) begin
			m.xfer(8'hFF, 8, rx);
			chk("read", exp_mem[(a + k) % 32768], rx);
		end
		chk("so enable", 8'h01, {7'h00, o_so_oe});
		m.stop();
	endtask
	task automatic wait_idle();
		for (int k = 0; k < 2000 && o_busy !== 1'h0; k++) begin
			@(negedge i_clock);
		end
		chk("idle", 8'h00, {7'h00, o_busy});
	endtask

	task automatic sc_latch();
		cmd(8'h0E);
		chk("latch", 8'h01, {7'h00, o_write_latch});
		status(8'h02);
		cmd(8'h04);
		chk("latch", 8'h00, {7'h00, o_write_latch});
		status(8'h00);
	endtask
	// A page write that starts near the page end and sends 66 bytes wraps and overwrites.
	task automatic sc_page();
		cmd(8'h06);
		wr(16'h013E, 8'h40, 66);
		for (int k = 0; k < 66; k++) begin
			exp_mem[16'h0100 + ((16'h3E + k) % 64)] = 8'(8'h40 + k);
		end
		chk("busy", 8'h01, {7'h00, o_busy});
		status(8'hFF);
		// A clear-latch command during programming must leave the latch set.
		cmd(8'h04);
		chk("latch", 8'h01, {7'h00, o_write_latch});
		wait_idle();
		chk("latch", 8'h00, {7'h00, o_write_latch});
		status(8'h00);
		rd(16'h0100, 64);
	endtask
	task automatic sc_wrap();
		cmd(8'h06);
		wr(16'h7FFF, 8'hA5, 1);
		exp_mem[32767] = 8'hA5;
		wait_idle();
		cmd(8'h06);
		wr(16'h0000, 8'h5A, 1);
		exp_mem[0] = 8'h5A;
		wait_idle();
		rd(16'hFFFF, 2);
	endtask
	task automatic sc_refuse();
		wr(16'h0000, 8'h77, 1);
		chk("busy", 8'h00, {7'h00, o_busy});
		cmd(8'h06);
		m.start();
		m.xfer(8'h02, 8, rx);
		m.xfer(8'h00, 8, rx);
		m.xfer(8'h00, 8, rx);
		m.xfer(8'h33, 4, rx);
		m.stop();
		chk("busy", 8'h00, {7'h00, o_busy});
		cmd(8'h04);
		rd(16'h0000, 1);
	endtask
	task automatic sc_guard();
		cmd(8'h06);
		swr(8'h84);
		wait_idle();
		status(8'h84);
		chk("guard", 8'h01, {6'h00, o_guard});
		cmd(8'h06);
		wr(16'h7FFF, 8'h11, 1);
		wait_idle();
		rd(16'h7FFF, 1);
		@(negedge i_clock);
		i_wp_n = 1'h0;
		cmd(8'h06);
		swr(8'h00);
		wait_idle();
		chk("pin enable", 8'h01, {7'h00, o_pin_enable});
		@(negedge i_clock);
		i_wp_n = 1'h1;
		cmd(8'h06);
		swr(8'h00);
		wait_idle();
		status(8'h00);
	endtask

	initial begin
		n_fail = 0;
		checks = 0;
		cyc    = 0;
		i_nrst = 1'h0;
		i_wp_n = 1'h1;
		// Two edges suffice, since the synchroniser resets to the idle pin levels.
		repeat (2) @(negedge i_clock);
		i_nrst = 1'h1;
		repeat (5) @(negedge i_clock);
		sc_latch();
		sc_page();
		sc_wrap();
		sc_refuse();
		sc_guard();
		wrap_up();
	end
endmodule

// ===== tb/sep_spi_master.sv
`timescale 1ns/10ps
module sep_spi_master (
	input  wire logic i_so,
	output logic      o_cs_n,
	output logic      o_sck,
	output logic      o_si
);
	// Mode 0: the serial clock rests low and only runs inside a frame.
	initial begin
		o_cs_n = 1'h1;
		o_sck  = 1'h0;
		o_si   = 1'h0;
	end
	// Frame delays of 101 and 99 keep every pin change clear of the rising system clock edges.
	task automatic start();
		o_cs_n = 1'h0;
		#101;
	endtask
	// Deselect falls in the clock low phase after the last bit, then the data line
	// flips so that a stale level is never mistaken for a driven one.
	task automatic stop();
		#99;
		o_cs_n = 1'h1;
		o_si   = ~o_si;
		#400;
	endtask
	// Sends n bits MSB first and samples the returned line just before each rising edge.
	// Phases of 62 and 63 ns keep the 125 ns period off the system clock edges.
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 0; i < n; i++) begin
			o_si = tx[7 - i];
			#62;
			rx[7 - i] = i_so;
			o_sck = 1'h1;
			#63;
			o_sck = 1'h0;
		end
	endtask
endmodule
